// file: smd_core.sv
// Sequential 8-bit two's-complement multiplier/divider with accumulator
// Notes on behaviour
// RL1: Multiplier or divisor is the current first-rank held operand.
// RL2: Accumulate-high adds prior upper half, sign-extended, at the low end.
// RL3: Single-length operand used as full length is sign-extended.
// RL4: Code 5 loads operand fractional, code 6 integer; mode is latched.
// RL5: Fractional division takes one clock less than integer division.
// RL6: Host loads zero upper half before single-length sign-extended divide.
// RL7: Signed 8-bit multiply; accumulation costs no extra clocks.
// RL8: Single- or double-length addend; held operand reusable as constant.
// RL9: Positive and negated multiply take equal clocks.
// RL10: Divide full accumulator; quotient to upper, remainder to lower.
// RL11: Remainder sign always follows the dividend sign.
// RL12: Dividend may be any prior result or freshly loaded operand.
// RL13: Strobe low with code 7 reads result onto the shared bus.
// RL14: Read gives upper half first, then lower half on continued code 7.
// RL15: Read during operand loading abandons it and returns to state 0.
// RL16: Repeated reads in state 0 swap the accumulator halves.
// RL17: Active-low direct reset initialises the sequencer.
// RL18: Held code 7 reaches state 0 within 13 clocks from anywhere.
// RL19: Integer mode: LSB weighs one, 16-bit and 8-bit signed ranges.
// RL20: Fractional mode: MSB weighs minus one, results rescaled.
// RL21: Fractional product LSB is zero unless addend supplies it.
// RL22: Mode stays as selected through a chained sequence.
// RL23: Host changes instruction code only while the clock is high.
// RL24: States 0,1,2,3,8,10 wait while strobe is high.
// RL25: Overflow cleared at each operation start, set on range escape.
// RL26: Without a new operand the previous held value is used.
// RL27: Everything acts on the rising clock edge.
// RL28: Bus driven only in read cycles, released otherwise.
module smd_core
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic direct_reset_n,
   // Host control
   input wire logic issue_strobe_n,
   input wire logic [2:0] instruction_code,
   // Shared data bus
   input wire logic [smd_pkg::SMD_W-1:0] bus_in,
   output logic [smd_pkg::SMD_W-1:0] bus_out,
   output logic bus_oe_n,
   // Status
   output logic overflow_flag
);
   import smd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [SMD_DW-1:0] sext16(input logic [SMD_W-1:0] v);
      return {{SMD_W{v[SMD_W-1]}}, v};
   endfunction

   // Returns {overflow, result}
   function automatic logic [SMD_DW:0] mul_acc(input logic [SMD_W-1:0] a,
      input logic [SMD_W-1:0] b, input logic [SMD_DW-1:0] add,
      input logic neg, input logic frac);
      logic signed [17:0] p;
      logic signed [17:0] s;
      p = $signed({{10{a[7]}}, a}) * $signed({{10{b[7]}}, b});
      if (frac)
         p = p <<< 1; // [RL20] [RL21]
      if (neg)
         p = -p; // [RL9]
      s = p + $signed({{2{add[15]}}, add});
      return {(s[17:15] != 3'h0) && (s[17:15] != 3'h7), s[15:0]}; // [RL25]
   endfunction

   // Returns {overflow, quotient, remainder}
   function automatic logic [SMD_DW:0] div_op(input logic [SMD_DW-1:0] d,
      input logic [SMD_W-1:0] x, input logic frac);
      logic signed [17:0] dd;
      logic signed [17:0] dv;
      logic signed [17:0] q;
      logic signed [17:0] r;
      dd = $signed({{2{d[15]}}, d});
      dv = $signed({{10{x[7]}}, x});
      if (frac)
         dv = dv <<< 1; // [RL20]
      if (dv == 18'sh0)
         return {1'b1, 8'h7f, BYTE_ZERO};
      q = dd / dv;
      r = dd % dv; // [RL11]
      if (frac)
         r = r >>> 1;
      return {(q[17:7] != 11'h000) && (q[17:7] != 11'h7ff), q[7:0], r[7:0]}; // [RL25]
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [2:0] code_s1_r;
   logic [2:0] code_s2_r;
   logic go_n_s1_r;
   logic go_n_s2_r;
   logic mr_n_s1_r;
   logic mr_n_s2_r;
   logic [SMD_W-1:0] bus_s1_r;
   logic [SMD_W-1:0] bus_s2_r;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         code_s1_r <= CODE_IDLE;
         code_s2_r <= CODE_IDLE;
         go_n_s1_r <= 1'b1;
         go_n_s2_r <= 1'b1;
         mr_n_s1_r <= 1'b1;
         mr_n_s2_r <= 1'b1;
         bus_s1_r <= BYTE_ZERO;
         bus_s2_r <= BYTE_ZERO;
      end
      else
      begin
         code_s1_r <= instruction_code; // [RL23]
         code_s2_r <= code_s1_r;
         go_n_s1_r <= issue_strobe_n;
         go_n_s2_r <= go_n_s1_r;
         mr_n_s1_r <= direct_reset_n;
         mr_n_s2_r <= mr_n_s1_r;
         bus_s1_r <= bus_in;
         bus_s2_r <= bus_s1_r;
      end
   end

   logic go;
   logic dr_clr;
   assign go = !go_n_s2_r;
   assign dr_clr = !mr_n_s2_r;

   ////////////////////////////////////////////////////////////////////////
   // Held operand

   logic ld_x;
   logic [SMD_W-1:0] x1;

   smd_operand_hold u_hold
   (
      .clock(clock),
      .rst(rst),
      .load(ld_x),
      .load_data(bus_s2_r),
      .held_first_rank_operand(x1)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer decode

   smd_state_e state_r;
   smd_state_e state_nxt;
   logic [SMD_CNT_W-1:0] cnt_r;
   logic frac_r;
   logic [SMD_W-1:0] z_r;
   logic [SMD_W-1:0] w_r;
   logic start_mul;
   logic start_div;
   logic do_read;
   logic ld_z;
   logic ld_w;
   logic wait_state;

   assign wait_state = (state_r == ST_IDLE) || (state_r == ST_XLD) || (state_r == ST_ZLD)
      || (state_r == ST_WLD) || (state_r == ST_MEND) || (state_r == ST_DEND);

   always_comb
   begin
      state_nxt = state_r;
      start_mul = 1'b0;
      start_div = 1'b0;
      do_read = 1'b0;
      ld_x = 1'b0;
      ld_z = 1'b0;
      ld_w = 1'b0;
      case (state_r)
         ST_IDLE, ST_XLD, ST_ZLD, ST_WLD, ST_MEND, ST_DEND:
         begin
            if (go) // [RL24]
            begin
               case (code_s2_r)
                  OP_READ:
                  begin
                     do_read = 1'b1; // [RL13]
                     state_nxt = ST_IDLE; // [RL15]
                  end
                  OP_DIV:
                  begin
                     start_div = 1'b1;
                     state_nxt = ST_DIV;
                  end
                  OP_FRAC, OP_INT:
                  begin
                     if ((state_r == ST_XLD || state_r == ST_ZLD || state_r == ST_WLD)
                         && code_s2_r == OP_FRAC)
                     begin
                        start_div = 1'b1;
                        state_nxt = ST_DIV;
                     end
                     else if (state_r == ST_XLD)
                     begin
                        ld_z = 1'b1;
                        state_nxt = ST_ZLD;
                     end
                     else if (state_r == ST_ZLD || state_r == ST_WLD)
                     begin
                        ld_w = 1'b1;
                        state_nxt = ST_WLD;
                     end
                     else
                     begin
                        ld_x = 1'b1; // [RL4]
                        state_nxt = ST_XLD;
                     end
                  end
                  default:
                  begin
                     start_mul = 1'b1;
                     state_nxt = ST_MUL;
                  end
               endcase
            end
         end
         ST_MUL:
         begin
            if (cnt_r == CNT_ZERO)
               state_nxt = ST_MEND;
         end
         ST_DIV:
         begin
            if (cnt_r == CNT_ZERO)
               state_nxt = ST_DEND;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) // [RL27]
   begin
      if (rst)
         state_r <= ST_IDLE;
      else if (dr_clr)
         state_r <= ST_IDLE; // [RL17]
      else
         state_r <= state_nxt;
   end

   // Same count for positive, negated and accumulating multiply
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         cnt_r <= CNT_ZERO;
      else if (dr_clr)
         cnt_r <= CNT_ZERO;
      else if (start_mul)
         cnt_r <= MUL_LAST; // [RL7] [RL9]
      else if (start_div)
         cnt_r <= frac_r ? DIV_FRAC_LAST : DIV_INT_LAST; // [RL5]
      else if (cnt_r != CNT_ZERO)
         cnt_r <= cnt_r - CNT_ONE;
   end

   // Mode changes only when an operand is loaded with code 5 or 6
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         frac_r <= 1'b0;
      else if (ld_x)
         frac_r <= (code_s2_r == OP_FRAC); // [RL4] [RL19] [RL22]
   end

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic operands

   logic acc_code;
   logic [SMD_DW-1:0] addend;
   logic [SMD_DW-1:0] dividend;
   logic [SMD_DW:0] mul_res;
   logic [SMD_DW:0] div_res;

   assign acc_code = (code_s2_r == OP_MACC) || (code_s2_r == OP_NMACC);

   always_comb
   begin
      addend = {z_r, w_r}; // [RL8]
      dividend = {z_r, w_r}; // [RL10] [RL12]
      case (state_r)
         ST_ZLD:
         begin
            addend = acc_code ? sext16(z_r) : {z_r, BYTE_ZERO}; // [RL2]
            dividend = sext16(z_r); // [RL3]
         end
         ST_WLD:
         begin
            addend = acc_code ? sext16(w_r) : {z_r, w_r}; // [RL3]
            dividend = sext16(w_r); // [RL6]
         end
         default:
         begin
            addend = acc_code ? {z_r, w_r} : {BYTE_ZERO, BYTE_ZERO}; // [RL7]
            dividend = sext16(z_r);
         end
      endcase
      if (code_s2_r == OP_DIV)
         dividend = {z_r, w_r}; // [RL10]
   end

   // Held operand used whether or not a fresh one was loaded
   assign mul_res = mul_acc(x1, bus_s2_r, addend, code_s2_r[0], frac_r); // [RL1] [RL26]
   assign div_res = div_op(dividend, x1, frac_r); // [RL1] [RL26]

   ////////////////////////////////////////////////////////////////////////
   // Accumulator, overflow and results

   logic [SMD_W-1:0] pend_z_r;
   logic [SMD_W-1:0] pend_w_r;
   logic pend_ovf_r;
   logic op_done;

   assign op_done = (state_r == ST_MUL || state_r == ST_DIV) && cnt_r == CNT_ZERO;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pend_z_r <= BYTE_ZERO;
         pend_w_r <= BYTE_ZERO;
         pend_ovf_r <= 1'b0;
      end
      else if (start_mul)
      begin
         {pend_ovf_r, pend_z_r, pend_w_r} <= mul_res;
      end
      else if (start_div)
      begin
         {pend_ovf_r, pend_z_r, pend_w_r} <= div_res; // [RL10]
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         z_r <= BYTE_ZERO;
         w_r <= BYTE_ZERO;
      end
      else if (op_done)
      begin
         z_r <= pend_z_r;
         w_r <= pend_w_r;
      end
      else if (do_read)
      begin
         z_r <= w_r; // [RL14] [RL16]
         w_r <= z_r;
      end
      else if (ld_z)
         z_r <= bus_s2_r;
      else if (ld_w)
         w_r <= bus_s2_r;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         overflow_flag <= 1'b0;
      else if (dr_clr || start_mul || start_div)
         overflow_flag <= 1'b0; // [RL25]
      else if (op_done)
         overflow_flag <= pend_ovf_r; // [RL25]
   end

   // Bus driven for exactly one cycle per read taken
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bus_out <= BYTE_ZERO;
         bus_oe_n <= 1'b1;
      end
      else
      begin
         bus_oe_n <= !(do_read && !dr_clr); // [RL28]
         if (do_read)
            bus_out <= z_r; // [RL13] [RL14]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst || dr_clr);

   chk_read_idle: assert property (do_read |=> state_r == ST_IDLE) // [RL15]
      else $error("read did not return sequencer to idle");
   chk_read_drive: assert property (do_read |=> !bus_oe_n && bus_out == $past(z_r)) // [RL14]
      else $error("read did not drive upper half");
   chk_read_swap: assert property (do_read |=> z_r == $past(w_r) && w_r == $past(z_r)) // [RL16]
      else $error("read did not swap halves");
   chk_bus_release: assert property (!bus_oe_n |-> $past(do_read)) // [RL28]
      else $error("bus driven outside a read");
   chk_wait_hold: assert property (wait_state && !go |=> $stable(state_r)) // [RL24]
      else $error("sequencer moved while strobe high");
   chk_mul_time: assert property (start_mul |-> ##4 state_r == ST_MUL ##1 state_r == ST_MEND) // [RL7]
      else $error("multiply length wrong");
   chk_div_frac: assert property (start_div && frac_r |-> ##8 state_r == ST_DIV ##1 state_r == ST_DEND) // [RL5]
      else $error("fractional divide length wrong");
   chk_div_int: assert property (start_div && !frac_r |-> ##9 state_r == ST_DIV ##1 state_r == ST_DEND) // [RL5]
      else $error("integer divide length wrong");
   chk_ovf_clear: assert property (start_mul || start_div |=> !overflow_flag) // [RL25]
      else $error("overflow not cleared at start");
   chk_mode_hold: assert property ($changed(frac_r) |-> $past(ld_x)) // [RL22]
      else $error("mode changed without operand load");
   chk_read_reach: assert property (state_r == ST_DIV |-> ##[1:12] state_r != ST_DIV) // [RL18]
      else $error("busy state not left in time");

   cov_mul_read: cover property (start_mul ##[1:10] do_read);
   cov_frac_div: cover property (start_div && frac_r);
   cov_two_reads: cover property (do_read ##1 do_read);
   cov_overflow: cover property (op_done ##1 overflow_flag);

endmodule // smd_core

// file: smd_core_tb.sv
// Self-checking bench for the sequential multiplier/divider
module smd_core_tb;
   import smd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SL = 4;
   localparam int LM = MUL_CYCLES + SL;
   localparam int LI = DIV_INT_CYCLES + SL;
   localparam int LF = DIV_FRAC_CYCLES + SL;

   typedef struct {
      logic [3:0][3:0] c;
      logic [3:0][7:0] d;
      int n;
      logic [15:0] res;
      logic ovf;
      bit full;
      int lat;
   } smd_row_s;

   logic clock;
   logic rst;
   logic direct_reset_n;
   logic issue_strobe_n;
   logic [2:0] instruction_code;
   logic [SMD_W-1:0] bus_in;
   logic [SMD_W-1:0] bus_out;
   logic bus_oe_n;
   logic overflow_flag;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int t0 = 0;
   logic [7:0] rd_q[$];
   int rd_t[$];

   // Codes first-issued in the top nibble/byte
   smd_row_s rows [13] = '{
      '{16'h6000, 32'h05030000, 2, 16'h000f, 1'b0, 1'b1, LM},
      '{16'h6100, 32'h05030000, 2, 16'hfff1, 1'b0, 1'b1, LM},
      '{16'h6200, 32'h02040000, 2, 16'hfff9, 1'b0, 1'b1, LM},
      '{16'h6300, 32'h02040000, 2, 16'hfff1, 1'b0, 1'b1, LM},
      '{16'h6400, 32'h07000000, 2, 16'hfeff, 1'b0, 1'b1, LI},
      '{16'h0000, 32'h03000000, 1, 16'h0015, 1'b0, 1'b1, LM},
      '{16'h6620, 32'h03fe0500, 3, 16'h000d, 1'b0, 1'b1, LM},
      '{16'h6665, 32'h0700f100, 4, 16'hfeff, 1'b0, 1'b1, LI},
      '{16'h5000, 32'h40400000, 2, 16'h2000, 1'b0, 1'b1, LM},
      '{16'h5000, 32'h80800000, 2, 16'h8000, 1'b1, 1'b0, LM},
      '{16'h5000, 32'h40100000, 2, 16'h0800, 1'b0, 1'b1, LM},
      '{16'h2000, 32'h10000000, 1, 16'h1000, 1'b0, 1'b1, LM},
      '{16'h5400, 32'h40000000, 2, 16'h2000, 1'b0, 1'b1, LF}
   };

   smd_core smd_core_i (
      .clock(clock),
      .rst(rst),
      .direct_reset_n(direct_reset_n),
      .issue_strobe_n(issue_strobe_n),
      .instruction_code(instruction_code),
      .bus_in(bus_in),
      .bus_out(bus_out),
      .bus_oe_n(bus_oe_n),
      .overflow_flag(overflow_flag)
   );

   smd_host smd_host_i (
      .clock(clock),
      .bus_out(bus_out),
      .bus_oe_n(bus_oe_n),
      .issue_strobe_n(issue_strobe_n),
      .instruction_code(instruction_code),
      .bus_in(bus_in)
   );

   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus capture and hang guard
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (bus_oe_n === 1'b0)
      begin
         rd_q.push_back(bus_out);
         rd_t.push_back(cyc);
      end
      if (cyc == 3000)
      begin
         error_cnt++;
         $display("[ERR] timeout expected 0 seen %0d", cyc);
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Hold reads until two bytes, leave the halves in original order
   task automatic rd_check(input logic [15:0] exp, input bit full, input int lat);
      int k = 0;
      while (rd_q.size() < 2 && k < 40)
      begin
         smd_host_i.issue(OP_READ, 8'h00);
         k++;
      end
      smd_host_i.idle(6);
      if (rd_q.size() % 2 == 1)
      begin
         smd_host_i.issue(OP_READ, 8'h00);
         smd_host_i.idle(6);
      end
      chk("latency", 16'(lat), 16'(rd_t[0] - t0));
      chk("upper", 16'(exp[15:8]), 16'(rd_q[0]));
      if (full)
      begin
         chk("lower", 16'(exp[7:0]), 16'(rd_q[1]));
         chk("swap", 16'(exp[15:8]), 16'(rd_q[2]));
      end
      rd_q.delete();
      rd_t.delete();
   endtask

   initial
   begin
      rst = 1'b1;
      direct_reset_n = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("oe_reset", 16'h0001, 16'(bus_oe_n));
      chk("ovf_reset", 16'h0000, 16'(overflow_flag));
      rst = 1'b0;
      smd_host_i.idle(2);
      foreach (rows[r])
      begin
         for (int i = 0; i < rows[r].n; i++)
         begin
            t0 = cyc;
            smd_host_i.issue(3'(rows[r].c[3-i]), rows[r].d[3-i]);
         end
         rd_check(rows[r].res, rows[r].full, rows[r].lat);
         chk("overflow", 16'(rows[r].ovf), 16'(overflow_flag));
      end
      // Read in mid-load, then state must be idle
      smd_host_i.issue(OP_INT, 8'h03);
      smd_host_i.idle(4);
      t0 = cyc;
      smd_host_i.issue(OP_INT, 8'h55);
      rd_check(16'h5500, 1'b0, SL);
      t0 = cyc;
      smd_host_i.issue(OP_MUL, 8'h02);
      rd_check(16'h0006, 1'b1, LM);
      // Overflow then direct reset
      smd_host_i.issue(OP_FRAC, 8'h80);
      smd_host_i.issue(OP_MUL, 8'h80);
      smd_host_i.idle(LM + 2);
      chk("ovf_set", 16'h0001, 16'(overflow_flag));
      direct_reset_n = 1'b0;
      smd_host_i.idle(1);
      direct_reset_n = 1'b1;
      smd_host_i.idle(4);
      chk("ovf_dreset", 16'h0000, 16'(overflow_flag));
      chk("oe_dreset", 16'h0001, 16'(bus_oe_n));
      end_of_test();
   end
endmodule // smd_core_tb

// file: smd_host.sv
// Host-side model that issues instructions to the multiplier/divider
module smd_host
(
   // Clock
   input wire logic clock,
   // Device drive of the shared bus
   input wire logic [7:0] bus_out,
   input wire logic bus_oe_n,
   // Instruction and bus side
   output logic issue_strobe_n,
   output logic [2:0] instruction_code,
   output logic [7:0] bus_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] host_drv;

   initial
   begin
      issue_strobe_n = 1'b1;
      instruction_code = 3'h0;
      host_drv = 8'h00;
   end

   // Shared bus: device drive wins while its enable is low
   always_comb
   begin
      bus_in = bus_oe_n ? host_drv : bus_out;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One instruction per cycle, changed just after the rising edge
   task automatic issue(input logic [2:0] code, input logic [7:0] data);
      issue_strobe_n = 1'b0;
      instruction_code = code;
      host_drv = data;
      @(posedge clock);
      #1;
   endtask

   // Released bus shows a changing pattern
   task automatic idle(input int n);
      repeat (n)
      begin
         issue_strobe_n = 1'b1;
         host_drv = ~host_drv;
         @(posedge clock);
         #1;
      end
   endtask
endmodule // smd_host

// file: smd_operand_hold.sv
// First-rank hold register for the multiplier/divisor operand
module smd_operand_hold
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Load side
   input wire logic load,
   input wire logic [smd_pkg::SMD_W-1:0] load_data,
   // Held value
   output logic [smd_pkg::SMD_W-1:0] held_first_rank_operand
);
   import smd_pkg::*;

   // Keeps its value until a new operand arrives
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         held_first_rank_operand <= BYTE_ZERO;
      end
      else if (load)
      begin
         held_first_rank_operand <= load_data;
      end
   end

endmodule // smd_operand_hold

// file: smd_pkg.sv
// Shared constants and types for the sequential multiplier/divider
package smd_pkg;

   localparam int SMD_W = 8;
   localparam int SMD_DW = 16;
   localparam int SMD_CNT_W = 4;

   // Instruction codes presented on instruction_code
   localparam logic [2:0] OP_MUL = 3'h0;
   localparam logic [2:0] OP_NMUL = 3'h1;
   localparam logic [2:0] OP_MACC = 3'h2;
   localparam logic [2:0] OP_NMACC = 3'h3;
   localparam logic [2:0] OP_DIV = 3'h4;
   localparam logic [2:0] OP_FRAC = 3'h5;
   localparam logic [2:0] OP_INT = 3'h6;
   localparam logic [2:0] OP_READ = 3'h7;

   // Reset and idle values
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0] CODE_IDLE = 3'h0;
   localparam logic [SMD_CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [SMD_CNT_W-1:0] CNT_ONE = 4'h1;

   // Timing, in ns, and derived clock counts (least times round up)
   localparam int CLK_PERIOD_NS = 40;
   localparam int MUL_TIME_NS = 160;
   localparam int DIV_INT_TIME_NS = 360;
   localparam int MUL_CYCLES = (MUL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_INT_CYCLES = (DIV_INT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_FRAC_CYCLES = DIV_INT_CYCLES - 1;
   localparam logic [SMD_CNT_W-1:0] MUL_LAST = SMD_CNT_W'(MUL_CYCLES - 1);
   localparam logic [SMD_CNT_W-1:0] DIV_INT_LAST = SMD_CNT_W'(DIV_INT_CYCLES - 1);
   localparam logic [SMD_CNT_W-1:0] DIV_FRAC_LAST = SMD_CNT_W'(DIV_FRAC_CYCLES - 1);

   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_XLD = 4'h1,
      ST_ZLD = 4'h2,
      ST_WLD = 4'h3,
      ST_MUL = 4'h4,
      ST_DIV = 4'h5,
      ST_MEND = 4'h8,
      ST_DEND = 4'ha
   } smd_state_e;

endpackage
